// ---- core/uart_pkg.sv ----
// shared constants, register map and carrier types for the serial channel
package uart_pkg;
	// register byte offsets (apb word aligned)
	localparam logic [7:0] MODE_OFFSET = 8'h00;
	localparam logic [7:0] TXBUF_OFFSET = 8'h04;
	localparam logic [7:0] RXBUF_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;
	localparam logic [7:0] DIVISOR_OFFSET = 8'h10;
	localparam logic [7:0] EVENT_OFFSET = 8'h14;
	// mode register field positions
	localparam int MODE_UNIT_BIT = 0;
	localparam int MODE_TX_BIT = 1;
	localparam int MODE_RX_BIT = 2;
	localparam int MODE_PAR_LSB = 3;
	localparam int MODE_LEN7_BIT = 5;
	localparam int MODE_STOP2_BIT = 6;
	localparam int MODE_ERRSEP_BIT = 7;
	// status field positions
	localparam int STAT_SHIFTING_BIT = 0;
	localparam int STAT_BUFFULL_BIT = 1;
	// event register field positions (rx error flags, cleared on read)
	localparam int EVT_PARITY_BIT = 0;
	localparam int EVT_FRAMING_BIT = 1;
	localparam int EVT_OVERRUN_BIT = 2;
	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BUF_RESET = 8'hff;
	localparam logic [15:0] DIVISOR_RESET = 16'h0010;
	// oversampling: ticks of the basic clock per bit
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID = 4'h7;
	// parity modes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	typedef struct packed {
		logic err_separate;
		logic stop2;
		logic len7;
		logic [1:0] parity;
		logic rx_enable;
		logic tx_enable;
		logic unit_enable;
	} serial_mode_t;

	typedef struct packed {
		logic overrun;
		logic framing;
		logic parity;
	} rx_err_t;

	typedef struct packed {
		logic tx_done_irq;
		logic rx_done_irq;
		logic rx_error_irq;
	} irq_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

// ---- core/uart_channel.sv ----
// asynchronous serial channel: apb registers, buffered transmitter, receiver
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module uart_channel
	import uart_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	input wire logic rx_pin,
	output logic tx_pin,
	// interrupt pulses
	output uart_pkg::irq_t irq
);
	import uart_pkg::*;

	serial_mode_t mode;
	logic [15:0] divisor;
	logic [15:0] baud_cnt;
	logic [7:0] tx_buffer;
	logic [7:0] tx_shift_reg;
	logic tx_buf_full_flag;
	logic tx_shifting_flag;
	tx_state_t tx_state;
	logic [3:0] tx_ovs;
	logic [2:0] tx_bit;
	logic tx_par;
	logic tx_stop_second;
	logic [7:0] rx_buffer;
	logic [7:0] rx_shift;
	rx_state_t rx_state;
	logic [3:0] rx_ovs;
	logic [2:0] rx_bit;
	logic rx_par;
	rx_err_t rx_err;
	logic [2:0] rx_sync;

	// bus decode
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_mode = paddr == MODE_OFFSET;
	wire hit_txbuf = paddr == TXBUF_OFFSET;
	wire hit_rxbuf = paddr == RXBUF_OFFSET;
	wire hit_status = paddr == STATUS_OFFSET;
	wire hit_div = paddr == DIVISOR_OFFSET;
	wire hit_evt = paddr == EVENT_OFFSET;
	wire mapped = hit_mode || hit_txbuf || hit_rxbuf || hit_status || hit_div || hit_evt;
	// both flags move on one edge, so a read never splits the pair
	wire [31:0] status_word = {30'h0, tx_buf_full_flag, tx_shifting_flag};
	wire [31:0] next_prdata = hit_mode ? {24'h0, mode} :
		hit_txbuf ? {24'h0, tx_buffer} :
		hit_rxbuf ? {24'h0, rx_buffer} :
		hit_status ? status_word :
		hit_div ? {16'h0, divisor} :
		hit_evt ? {29'h0, rx_err} : 32'h0;

	// baud generator: one tick per oversample slot, frozen while unit is off
	wire unit_on = mode.unit_enable;
	wire tick = unit_on && (baud_cnt == 16'h0);
	wire [15:0] next_baud_cnt = (!unit_on || baud_cnt == 16'h0) ? divisor - 16'h1 : baud_cnt - 16'h1;

	// rx pin: three flops, change taken on a tick when second and third agree
	logic rx_level;
	wire rx_agree = rx_sync[1] == rx_sync[2];

	// transmitter
	wire tx_run = unit_on && mode.tx_enable;
	wire buf_write = wr && hit_txbuf && tx_run;
	wire tx_slot_end = tick && tx_ovs == OVS_LAST;
	wire [2:0] last_bit = mode.len7 ? 3'h6 : 3'h7;
	wire tx_load = tx_run && tx_state == TX_IDLE && tx_buf_full_flag;
	wire tx_final_stop = tx_state == TX_STOP && (!mode.stop2 || tx_stop_second);
	wire tx_frame_end = tx_slot_end && tx_final_stop;
	wire [7:0] tx_masked = mode.len7 ? {1'b0, tx_shift_reg[6:0]} : tx_shift_reg;
	wire tx_par_bit = mode.parity == PAR_ODD ? ~(^tx_masked) : mode.parity == PAR_EVEN ? ^tx_masked : 1'b0;

	// receiver
	wire rx_run = unit_on && mode.rx_enable;
	wire rx_mid = tick && rx_ovs == OVS_MID;
	wire rx_stop_seen = rx_state == RX_STOP && rx_mid;
	wire [7:0] rx_char = mode.len7 ? {1'b0, rx_shift[7:1]} : rx_shift;
	wire rx_par_bad = (mode.parity == PAR_EVEN && (^rx_char ^ rx_par)) ||
		(mode.parity == PAR_ODD && !(^rx_char ^ rx_par));
	wire rx_frame_bad = !rx_level;
	logic rx_unread;
	wire rx_over = rx_unread;
	wire rx_any_err = rx_par_bad || rx_frame_bad || rx_over;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			mode <= MODE_RESET;
			divisor <= DIVISOR_RESET;
			baud_cnt <= 16'h0;
			rx_sync <= 3'h7;
			rx_level <= 1'b1;
		end else if (clk_en) begin
			pready <= access && !pready;
			pslverr <= access && !pready && !mapped;
			prdata <= (rd && !pready) ? next_prdata : 32'h0;
			if (wr && !pready && hit_mode)
				mode <= pwdata[7:0];
			if (wr && !pready && hit_div)
				divisor <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
			baud_cnt <= next_baud_cnt;
			rx_sync <= {rx_sync[1:0], rx_pin};
			if (rx_agree && tick)
				rx_level <= rx_sync[2];
		end
	end

	// transmit buffer and its full flag
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tx_buffer <= BUF_RESET;
			tx_buf_full_flag <= 1'b0;
		end else if (clk_en) begin
			if (!tx_run) begin
				tx_buf_full_flag <= 1'b0;
			end else if (buf_write && !pready) begin
				tx_buffer <= pwdata[7:0];
				tx_buf_full_flag <= 1'b1;
			end else if (tx_load) begin
				tx_buf_full_flag <= 1'b0;
			end
		end
	end

	// transmit sequencer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tx_state <= TX_IDLE;
			tx_shift_reg <= BUF_RESET;
			tx_shifting_flag <= 1'b0;
			tx_ovs <= 4'h0;
			tx_bit <= 3'h0;
			tx_par <= 1'b0;
			tx_stop_second <= 1'b0;
			tx_pin <= 1'b1;
			irq.tx_done_irq <= 1'b0;
		end else if (clk_en) begin
			irq.tx_done_irq <= 1'b0;
			if (!tx_run) begin
				tx_state <= TX_IDLE;
				tx_shifting_flag <= 1'b0;
				tx_pin <= 1'b1;
			end else begin
				if (tick)
					tx_ovs <= tx_ovs + 4'h1;
				unique case (tx_state)
				TX_IDLE: begin
					tx_pin <= 1'b1;
					if (tx_load) begin
						tx_shift_reg <= tx_buffer;
						tx_shifting_flag <= 1'b1;
						tx_state <= TX_START;
						tx_ovs <= 4'h0;
						tx_pin <= 1'b0;
					end
				end
				TX_START: begin
					tx_par <= tx_par_bit;
					if (tx_slot_end) begin
						tx_state <= TX_DATA;
						tx_bit <= 3'h0;
						tx_pin <= tx_shift_reg[0];
					end
				end
				TX_DATA: begin
					if (tx_slot_end) begin
						if (tx_bit == last_bit) begin
							tx_state <= (mode.parity == PAR_NONE) ? TX_STOP : TX_PARITY;
							tx_pin <= (mode.parity == PAR_NONE) ? 1'b1 : tx_par;
							tx_stop_second <= 1'b0;
						end else begin
							tx_bit <= tx_bit + 3'h1;
							tx_pin <= tx_shift_reg[tx_bit + 3'h1];
						end
					end
				end
				TX_PARITY: begin
					if (tx_slot_end) begin
						tx_state <= TX_STOP;
						tx_pin <= 1'b1;
						tx_stop_second <= 1'b0;
					end
				end
				TX_STOP: begin
					if (tick && tx_ovs == 4'h0 && tx_final_stop && tx_shifting_flag) begin
						irq.tx_done_irq <= 1'b1;
						tx_shifting_flag <= tx_buf_full_flag;
					end
					if (tx_slot_end) begin
						tx_stop_second <= 1'b1;
						if (tx_frame_end)
							tx_state <= TX_IDLE;
					end
				end
				endcase
			end
		end
	end

	// receive sequencer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rx_state <= RX_IDLE;
			rx_buffer <= BUF_RESET;
			rx_shift <= 8'h0;
			rx_ovs <= 4'h0;
			rx_bit <= 3'h0;
			rx_par <= 1'b0;
			rx_err <= '0;
			rx_unread <= 1'b0;
			irq.rx_done_irq <= 1'b0;
			irq.rx_error_irq <= 1'b0;
		end else if (clk_en) begin
			irq.rx_done_irq <= 1'b0;
			irq.rx_error_irq <= 1'b0;
			if (rd && !pready && hit_rxbuf)
				rx_unread <= 1'b0;
			if (rd && !pready && hit_evt)
				rx_err <= '0;
			if (!rx_run) begin
				rx_state <= RX_IDLE;
			end else begin
				if (tick)
					rx_ovs <= rx_ovs + 4'h1;
				unique case (rx_state)
				RX_IDLE: begin
					if (tick && !rx_level) begin
						rx_state <= RX_START;
						rx_ovs <= 4'h1;
					end
				end
				RX_START: begin
					if (rx_mid)
						rx_state <= rx_level ? RX_IDLE : RX_DATA;
					rx_bit <= 3'h0;
				end
				RX_DATA: begin
					if (rx_mid) begin
						rx_shift <= {rx_level, rx_shift[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == last_bit)
							rx_state <= (mode.parity == PAR_NONE) ? RX_STOP : RX_PARITY;
					end
				end
				RX_PARITY: begin
					if (rx_mid) begin
						rx_par <= rx_level;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_stop_seen) begin
						rx_state <= RX_IDLE;
						if (!rx_over) begin
							rx_buffer <= rx_char;
							rx_unread <= 1'b1;
						end
						rx_err <= rx_err | {rx_over, rx_frame_bad, rx_par_bad};
						if (rx_any_err && !mode.err_separate)
							irq.rx_error_irq <= 1'b1;
						else
							irq.rx_done_irq <= 1'b1;
					end
				end
				endcase
			end
		end
	end
endmodule // uart_channel

// ---- tb/uart_channel_props.sv ----
// port checker for the serial channel
`timescale 1ns/1ps
module uart_channel_props
	import uart_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and events
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire uart_pkg::irq_t irq
);
	logic rx_on;
	wire mode_wr = psel && penable && pready && pwrite && paddr == MODE_OFFSET;
	// snooped receive enable, unit gate included
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			rx_on <= 1'b0;
		else if (mode_wr)
			rx_on <= pwdata[MODE_RX_BIT] && pwdata[MODE_UNIT_BIT];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer");
	reset_quiet_a: assert property (resetn && !$past(resetn) |-> tx_pin && irq == 3'h0)
		else $error("reset left line or event active");
	done_on_stop_a: assert property (irq.tx_done_irq |=> tx_pin [*8])
		else $error("tx done away from stop bit");
	start_len_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
		else $error("short low bit");
	rx_quiet_a: assert property (!rx_on && !$past(rx_on) |-> !irq.rx_done_irq && !irq.rx_error_irq)
		else $error("rx event while disabled");
endmodule // uart_channel_props

bind uart_channel uart_channel_props i_uart_channel_props (.ref_clk, .resetn, .clk_en, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_pin, .irq);

// ---- tb/uart_remote.sv ----
// remote transceiver model on the serial pins
`timescale 1ns/1ps
module uart_remote #(
	parameter int BIT_CYC = 16
) (
	// clock
	input wire logic ref_clk,
	// pins
	input wire logic tx_pin,
	output logic rx_pin
);
	logic [7:0] got[$];
	logic [7:0] sh;
	initial rx_pin = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_pin <= f[i];
			repeat (BIT_CYC) @(posedge ref_clk);
		end
	endtask
	// mid-bit sampling, 8N1 only
	always begin
		@(negedge tx_pin);
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			sh[i] = tx_pin;
		end
		repeat (BIT_CYC) @(posedge ref_clk);
		if (tx_pin)
			got.push_back(sh);
	end
endmodule // uart_remote

// ---- tb/uart_channel_tb_top.sv ----
// self-checking bench for the serial channel
`timescale 1ns/1ps
module uart_channel_tb_top;
	import uart_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, rx_pin, tx_pin, errv;
	irq_t irq;
	int error_cnt = 0;
	int compares = 0;
	int tx_cnt = 0;
	int rx_cnt = 0;
	int rx_err_cnt = 0;
	always #2.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		if (irq.tx_done_irq === 1'b1)
			tx_cnt++;
		if (irq.rx_done_irq === 1'b1)
			rx_cnt++;
		if (irq.rx_error_irq === 1'b1)
			rx_err_cnt++;
	end
	uart_channel i_uart_channel (.ref_clk, .resetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_pin, .irq);
	uart_remote #(.BIT_CYC(16)) i_uart_remote (.ref_clk, .tx_pin, .rx_pin);
	task automatic test_done();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic fail();
		error_cnt++;
		$display("FAIL %0t: wait ran out", $time);
		test_done();
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 20)
			fail();
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rdv, exp);
	endtask
	task automatic wait_tx(input int n);
		int k;
		k = 0;
		while (tx_cnt < n && k < 400) begin
			@(negedge ref_clk);
			k++;
		end
		if (k == 400)
			fail();
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		chk_rd(MODE_OFFSET, 32'h0);
		chk_rd(TXBUF_OFFSET, 32'hff);
		chk_rd(RXBUF_OFFSET, 32'hff);
		chk_rd(STATUS_OFFSET, 32'h0);
		chk_rd(8'h18, 32'h0);
		cmp(errv, 32'h1);
		wr(DIVISOR_OFFSET, 32'h0);
		chk_rd(DIVISOR_OFFSET, 32'h1);
		// no shared synchronous unit sits on these pins in the bench
		wr(MODE_OFFSET, 32'h1);
		cmp(tx_pin, 32'h1);
		wr(TXBUF_OFFSET, 32'h55);
		chk_rd(STATUS_OFFSET, 32'h0);
		wr(MODE_OFFSET, 32'h7);
		wr(TXBUF_OFFSET, 32'ha5);
		chk_rd(STATUS_OFFSET, 32'h1);
		wr(TXBUF_OFFSET, 32'h3c);
		chk_rd(STATUS_OFFSET, 32'h3);
		wait_tx(1);
		repeat (20) @(posedge ref_clk);
		chk_rd(STATUS_OFFSET, 32'h1);
		wait_tx(2);
		repeat (40) @(posedge ref_clk);
		chk_rd(STATUS_OFFSET, 32'h0);
		cmp(tx_pin, 32'h1);
		cmp(i_uart_remote.got[0], 32'ha5);
		cmp(i_uart_remote.got[1], 32'h3c);
		i_uart_remote.send(8'h96);
		repeat (20) @(posedge ref_clk);
		cmp(rx_cnt, 32'h1);
		chk_rd(RXBUF_OFFSET, 32'h96);
		chk_rd(EVENT_OFFSET, 32'h0);
		fork
			i_uart_remote.send(8'h4b);
			begin
				repeat (60) @(posedge ref_clk);
				wr(MODE_OFFSET, 32'h3);
			end
		join
		i_uart_remote.send(8'h11);
		repeat (20) @(posedge ref_clk);
		cmp(rx_cnt, 32'h1);
		chk_rd(RXBUF_OFFSET, 32'h96);
		// even parity expected, remote sends none: its stop bit lands as a bad parity bit
		wr(MODE_OFFSET, 32'h1d);
		i_uart_remote.send(8'h03);
		repeat (30) @(posedge ref_clk);
		cmp(rx_err_cnt, 32'h1);
		cmp(rx_cnt, 32'h1);
		chk_rd(EVENT_OFFSET, 32'h1);
		chk_rd(RXBUF_OFFSET, 32'h03);
		wr(MODE_OFFSET, 32'h3);
		wr(TXBUF_OFFSET, 32'h5a);
		repeat (30) @(posedge ref_clk);
		wr(MODE_OFFSET, 32'h0);
		chk_rd(STATUS_OFFSET, 32'h0);
		wr(MODE_OFFSET, 32'h7);
		wr(TXBUF_OFFSET, 32'hc3);
		repeat (40) @(posedge ref_clk);
		resetn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (200) @(posedge ref_clk);
		cmp(tx_cnt, 32'h2);
		test_done();
	end
endmodule // uart_channel_tb_top
